// *** dv/crxoh_chk.sv ***
module crxoh_chk (
  input logic sys_clk,
  input logic rst_n,
  input logic cmdValid,
  input logic cmdReady,
  input crxoh_pkg::crxoh_cmd_type cmd,
  input logic rspValid,
  input logic txValid,
  input logic txReady,
  input logic [crxoh_pkg::OBJ_NUM_W-1:0] txObjectNumber,
  input crxoh_pkg::crxoh_frame_type txFrame
);
  import crxoh_pkg::*;

  // ----------------------------------------------------------------
  // Link checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  cmd_hold_a: assert property (
    cmdValid && !cmdReady |=> cmdValid && $stable(cmd))
    else $error("command changed before taken");
  read_answer_a: assert property (
    cmdValid && cmdReady && !cmd.writeNotRead |=> rspValid ##1 !rspValid)
    else $error("read answer not a one-cycle pulse");
  write_silent_a: assert property (
    cmdValid && cmdReady && cmd.writeNotRead |=> !rspValid)
    else $error("write gave a read answer");
  tx_hold_a: assert property (
    txValid && !txReady |=> txValid && $stable(txFrame) && $stable(txObjectNumber))
    else $error("transmit frame changed while stalled");
  tx_range_a: assert property (
    txValid |-> txObjectNumber != 6'h00 && txObjectNumber <= 6'h20)
    else $error("transmit object number out of range");
  tx_release_a: assert property (
    txValid && txReady |=> !txValid)
    else $error("next transmit picked without a gap");
  tx_request_a: assert property (
    cmdValid && cmdReady && cmd.writeNotRead && cmd.selCtrl && cmd.obj.transmitRequest
    |=> ##[0:40] txValid)
    else $error("transmit request not sent");
  scan_bound_a: assert property (
    $fell(cmdReady) |-> ##[1:40] cmdReady)
    else $error("scan longer than all objects");
endmodule

// *** dv/crxoh_tb.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import crxoh_pkg::*;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic setupValid = 1'b0;
  logic answerValid = 1'b0;
  logic readValid = 1'b0;
  logic busFrameValid = 1'b0;
  logic busTxReady = 1'b0;
  logic [OBJ_NUM_W-1:0] setupObjectNumber = '0, answerObjectNumber = '0, readObjectNumber = '0;
  logic [DLC_W-1:0] answerDlc = '0;
  logic [DATA_W-1:0] answerData = '0;
  crxoh_obj_type setupObject = '0, readObject, o;
  crxoh_frame_type busFrame = '0, busTxFrame, f;
  logic setupReady, answerReady, readReady, readDoneValid, busFrameReady, busTxValid;
  logic [OBJ_NUM_W-1:0] busTxObjectNumber, n;
  logic [NUM_OBJ-1:0] objNewData, objIntPending;
  logic sawFull = 1'b0;
  int errors = 0;
  int comparisons = 0;

  crxoh_link_if link();
  crxoh_device crxoh_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .objNewData(objNewData), .objIntPending(objIntPending));
  crxoh_host crxoh_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .setupValid(setupValid), .setupReady(setupReady), .setupObjectNumber(setupObjectNumber),
    .setupObject(setupObject), .answerValid(answerValid), .answerReady(answerReady),
    .answerObjectNumber(answerObjectNumber), .answerDlc(answerDlc), .answerData(answerData),
    .readValid(readValid), .readReady(readReady), .readObjectNumber(readObjectNumber),
    .readDoneValid(readDoneValid), .readObject(readObject), .busFrameValid(busFrameValid),
    .busFrameReady(busFrameReady), .busFrame(busFrame), .busTxValid(busTxValid),
    .busTxReady(busTxReady), .busTxObjectNumber(busTxObjectNumber), .busTxFrame(busTxFrame));
  crxoh_chk crxoh_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .cmdValid(link.cmdValid),
    .cmdReady(link.cmdReady), .cmd(link.cmd), .rspValid(link.rspValid),
    .txValid(link.txValid), .txReady(link.txReady), .txObjectNumber(link.txObjectNumber),
    .txFrame(link.txFrame));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  function automatic logic rdy(input int s);
    case (s)
      0: return setupReady;
      1: return answerReady;
      2: return readReady;
      3: return busFrameReady;
      4: return busTxValid;
      default: return readDoneValid;
    endcase
  endfunction

  task automatic tmo();
    errors++;
    $display("FAIL %0t wait timed out", $time);
    end_of_test();
  endtask

  task automatic hs(input int s);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (rdy(s) !== 1'b1)
    begin
      if (s == 3)
        sawFull = 1'b1;
      k++;
      if (k > 300)
        tmo();
      @(posedge sys_clk);
    end
  endtask

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic setupObj(input logic [OBJ_NUM_W-1:0] num, input crxoh_obj_type obj);
    @(posedge sys_clk);
    setupValid <= 1'b1;
    setupObjectNumber <= num;
    setupObject <= obj;
    hs(0);
    setupValid <= 1'b0;
  endtask

  task automatic answer(input logic [OBJ_NUM_W-1:0] num, input logic [DLC_W-1:0] dlc);
    @(posedge sys_clk);
    answerValid <= 1'b1;
    answerObjectNumber <= num;
    answerDlc <= dlc;
    answerData <= {58'h0, num};
    hs(1);
    answerValid <= 1'b0;
  endtask

  task automatic readObj(input logic [OBJ_NUM_W-1:0] num);
    @(posedge sys_clk);
    readValid <= 1'b1;
    readObjectNumber <= num;
    hs(2);
    readValid <= 1'b0;
    hs(5);
    o = readObject;
  endtask

  task automatic sendFrame(input crxoh_frame_type fr);
    @(posedge sys_clk);
    busFrameValid <= 1'b1;
    busFrame <= fr;
    hs(3);
    busFrameValid <= 1'b0;
    busFrame <= ~fr;
  endtask

  task automatic getTx();
    @(posedge sys_clk);
    busTxReady <= 1'b1;
    hs(4);
    n = busTxObjectNumber;
    f = busTxFrame;
    busTxReady <= 1'b0;
  endtask

  task automatic drain();
    int c;
    c = 0;
    for (int k = 0; k < 300 && c < 3; k++)
    begin
      @(posedge sys_clk);
      c = (link.cmdReady === 1'b1) ? c + 1 : 0;
    end
    if (c < 3)
      tmo();
  endtask

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk(objNewData === 32'h0000_0000 && setupReady === 1'b1, "reset state");
    o = '0;
    o.id = 29'h048C_0000;
    o.receiveInterruptEnable = 1'b1;
    o.dlc = 4'h8;
    setupObj(6'h03, o);
    f = '0;
    f.id = 29'h048C_0000;
    f.dlc = 4'h8;
    f.data = 64'h0807_0605_0403_0201;
    sendFrame(f);
    drain();
    chk(objNewData[2] === 1'b1 && objIntPending[2] === 1'b1, "rx flags");
    f.data = 64'h1817_1615_1413_1211;
    sendFrame(f);
    drain();
    readObj(6'h03);
    chk(o.data === 64'h1817_1615_1413_1211 && o.dlc === 4'h8, "rx data");
    chk(o.messageLostFlag === 1'b1 && o.newDataFlag === 1'b1, "lost flag");
    readObj(6'h03);
    chk(o.interruptPending === 1'b0 && o.newDataFlag === 1'b0, "read clear");
    $display("test rx done");
    o = '0;
    o.extendedIdFlag = 1'b1;
    o.id = 29'h0ABC_0000;
    o.useAcceptanceMask = 1'b1;
    o.idMaskBits = 29'h1FFF_0000;
    setupObj(6'h05, o);
    o.useAcceptanceMask = 1'b0;
    o.id = 29'h0ABC_1234;
    setupObj(6'h06, o);
    o = '0;
    o.useAcceptanceMask = 1'b1;
    setupObj(6'h07, o);
    f = '0;
    f.extendedIdFlag = 1'b1;
    f.id = 29'h0ABC_1234;
    f.dlc = 4'h2;
    f.data = 64'h0000_0000_0000_AA55;
    sendFrame(f);
    f.id = 29'h0ABD_1234;
    sendFrame(f);
    drain();
    readObj(6'h05);
    chk(o.id === 29'h0ABC_1234 && o.newDataFlag === 1'b1, "masked rx");
    chk(o.data[15:0] === 16'hAA55 && o.dlc === 4'h2, "short data");
    chk(o.maskExtendedFlag === 1'b1 && o.objectValid === 1'b1, "mask ext set");
    readObj(6'h06);
    chk(o.newDataFlag === 1'b0, "first match only");
    readObj(6'h07);
    chk(o.newDataFlag === 1'b1 && o.id === 29'h0ABD_1234, "zero mask");
    $display("test mask done");
    answer(6'h07, 4'h1);
    answer(6'h06, 4'h1);
    answer(6'h05, 4'h2);
    getTx();
    chk(n === 6'h07, "first tx");
    getTx();
    chk(n === 6'h05 && f.id === 29'h0ABC_1234 && f.remote === 1'b1, "priority");
    getTx();
    chk(n === 6'h06 && f.dlc === 4'h1, "last tx");
    $display("test tx done");
    f = '0;
    f.remote = 1'b1;
    f.id = 29'h048C_0000;
    repeat (6) sendFrame(f);
    chk(sawFull === 1'b1, "fifo never full");
    drain();
    chk(objNewData === 32'h0000_0040, "remote stored");
    readObj(6'h07);
    chk(o.data === 64'h0000_0000_0000_0007 && o.dlc === 4'h0, "remote kept data");
    chk(o.id === 29'h048C_0000 && o.transmitRequest === 1'b0, "remote header");
    chk(o.messageLostFlag === 1'b1, "remote lost flag");
    $display("test fifo done");
    end_of_test();
  end
endmodule

// *** rtl/crxoh_device.sv ***
module crxoh_device #(
  parameter int NumObj = crxoh_pkg::NUM_OBJ,
  parameter int FifoDepth = crxoh_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  crxoh_link_if.device link,
  output logic [NumObj-1:0] objNewData,
  output logic [NumObj-1:0] objIntPending
);
  import crxoh_pkg::*;

  localparam int IDX_W = $clog2(NumObj);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_SCAN} crxoh_dev_fsm_type;

  typedef struct packed {
    crxoh_dev_fsm_type fsm;
    logic [IDX_W-1:0] scanIdx;
    crxoh_obj_type [NumObj-1:0] objs;
    logic rspValid;
    crxoh_obj_type rsp;
    logic txValid;
    logic [IDX_W-1:0] txIdx;
    logic [OBJ_NUM_W-1:0] txNum;
    crxoh_frame_type txFrame;
  } crxoh_dev_state_type;

  crxoh_dev_state_type state_q;
  crxoh_dev_state_type state_d;

  logic fifoInReady;
  logic headValid;
  logic headPop;
  logic [FRAME_W-1:0] headBits;
  crxoh_frame_type head;
  logic scanHit;
  logic scanLast;
  logic txFound;
  logic [IDX_W-1:0] txPick;
  logic cmdNumOk;
  logic [IDX_W-1:0] cmdIdx;

  // ----------------------------------------------------------------
  // Received frame queue
  // ----------------------------------------------------------------
  crxoh_fifo #(
    .WIDTH(FRAME_W),
    .DEPTH(FifoDepth)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(link.frameValid),
    .inReady(fifoInReady),
    .inData(link.frame),
    .outValid(headValid),
    .outReady(headPop),
    .outData(headBits)
  );

  assign head = crxoh_frame_type'(headBits);
  assign link.frameReady = fifoInReady;

  // ----------------------------------------------------------------
  // Acceptance filter
  // ----------------------------------------------------------------
  function automatic logic objMatch(crxoh_obj_type o, crxoh_frame_type f);
    logic [ID_W-1:0] care;
    logic extOk;
    logic dirOk;
    care = o.useAcceptanceMask ? o.idMaskBits : '1;
    if (!f.extendedIdFlag)
    begin
      care[STD_ID_LSB-1:0] = '0;
    end
    extOk = (o.extendedIdFlag == f.extendedIdFlag)
      || (o.useAcceptanceMask && !o.maskExtendedFlag);
    dirOk = (o.directionTx == f.remote)
      || (o.useAcceptanceMask && !o.maskDirection);
    return o.objectValid && (((o.id ^ f.id) & care) == '0) && extOk && dirOk;
  endfunction

  assign scanHit = objMatch(state_q.objs[state_q.scanIdx], head);
  assign scanLast = state_q.scanIdx == IDX_W'(NumObj - 1);
  assign headPop = (state_q.fsm == ST_SCAN) && (scanHit || scanLast);

  // ----------------------------------------------------------------
  // Transmit pick and command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    txFound = 1'b0;
    txPick = '0;
    for (int i = NumObj - 1; i >= 0; i--)
    begin
      if (state_q.objs[i].objectValid && state_q.objs[i].transmitRequest)
      begin
        txFound = 1'b1;
        txPick = IDX_W'(i);
      end
    end
  end

  assign cmdNumOk = (link.cmd.objectNumber != '0)
    && (link.cmd.objectNumber <= OBJ_NUM_W'(NumObj));
  assign cmdIdx = IDX_W'(link.cmd.objectNumber - 1'b1);
  assign link.cmdReady = state_q.fsm == ST_IDLE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    crxoh_obj_type o;
    o = '0;
    state_d = state_q;
    state_d.rspValid = 1'b0;

    if (state_q.txValid && link.txReady)
    begin
      state_d.objs[state_q.txIdx].transmitRequest = 1'b0;
      state_d.txValid = 1'b0;
    end
    else if (!state_q.txValid && txFound)
    begin
      state_d.txValid = 1'b1;
      state_d.txIdx = txPick;
      state_d.txNum = OBJ_NUM_W'(txPick) + 1'b1;
      state_d.txFrame.id = state_q.objs[txPick].id;
      state_d.txFrame.extendedIdFlag = state_q.objs[txPick].extendedIdFlag;
      state_d.txFrame.remote = !state_q.objs[txPick].directionTx;
      state_d.txFrame.dlc = state_q.objs[txPick].dlc;
      state_d.txFrame.data = state_q.objs[txPick].data;
    end

    case (state_q.fsm)
      ST_IDLE:
      begin
        if (link.cmdValid)
        begin
          o = state_d.objs[cmdIdx];
          if (link.cmd.writeNotRead)
          begin
            if (link.cmd.selMask)
            begin
              o.idMaskBits = link.cmd.obj.idMaskBits;
              o.maskExtendedFlag = link.cmd.obj.maskExtendedFlag;
              o.maskDirection = link.cmd.obj.maskDirection;
            end
            if (link.cmd.selArb)
            begin
              o.id = link.cmd.obj.id;
              o.extendedIdFlag = link.cmd.obj.extendedIdFlag;
              o.directionTx = link.cmd.obj.directionTx;
              o.objectValid = link.cmd.obj.objectValid;
            end
            if (link.cmd.selCtrl)
            begin
              o.useAcceptanceMask = link.cmd.obj.useAcceptanceMask;
              o.remoteEnable = link.cmd.obj.remoteEnable;
              o.receiveInterruptEnable = link.cmd.obj.receiveInterruptEnable;
              o.endOfBuffer = link.cmd.obj.endOfBuffer;
              o.transmitRequest = link.cmd.obj.transmitRequest;
              o.newDataFlag = link.cmd.obj.newDataFlag;
              o.messageLostFlag = link.cmd.obj.messageLostFlag;
              o.interruptPending = link.cmd.obj.interruptPending;
              o.dlc = link.cmd.obj.dlc;
            end
            if (link.cmd.selData)
            begin
              o.data = link.cmd.obj.data;
            end
          end
          else
          begin
            state_d.rspValid = 1'b1;
            state_d.rsp = cmdNumOk ? state_q.objs[cmdIdx] : '0;
            if (link.cmd.clrIntPending)
            begin
              o.interruptPending = 1'b0;
            end
            if (link.cmd.clrNewData)
            begin
              o.newDataFlag = 1'b0;
            end
          end
          if (cmdNumOk)
          begin
            state_d.objs[cmdIdx] = o;
          end
        end
        else if (headValid)
        begin
          state_d.fsm = ST_SCAN;
          state_d.scanIdx = '0;
        end
      end
      ST_SCAN:
      begin
        if (scanHit)
        begin
          state_d.fsm = ST_IDLE;
          o = state_d.objs[state_q.scanIdx];
          if (!head.remote)
          begin
            o.messageLostFlag = o.messageLostFlag | o.newDataFlag;
            o.id = head.id;
            o.extendedIdFlag = head.extendedIdFlag;
            o.dlc = head.dlc;
            o.data = head.data;
            o.newDataFlag = 1'b1;
            o.transmitRequest = 1'b0;
            o.interruptPending = o.interruptPending | o.receiveInterruptEnable;
          end
          else if (o.remoteEnable)
          begin
            o.transmitRequest = 1'b1;
          end
          else if (o.useAcceptanceMask)
          begin
            o.messageLostFlag = o.messageLostFlag | o.newDataFlag;
            o.transmitRequest = 1'b0;
            o.id = head.id;
            o.extendedIdFlag = head.extendedIdFlag;
            o.dlc = head.dlc;
            o.newDataFlag = 1'b1;
            o.interruptPending = o.interruptPending | o.receiveInterruptEnable;
          end
          // Otherwise the remote frame leaves no trace
          state_d.objs[state_q.scanIdx] = o;
        end
        else if (scanLast)
        begin
          state_d.fsm = ST_IDLE;
        end
        else
        begin
          state_d.scanIdx = state_q.scanIdx + 1'b1;
        end
      end
      default:
      begin
        state_d.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.rspValid = state_q.rspValid;
  assign link.rsp = state_q.rsp;
  assign link.txValid = state_q.txValid;
  assign link.txObjectNumber = state_q.txNum;
  assign link.txFrame = state_q.txFrame;

  for (genvar g = 0; g < NumObj; g++)
  begin : g_flags
    assign objNewData[g] = state_q.objs[g].newDataFlag;
    assign objIntPending[g] = state_q.objs[g].interruptPending;
  end

endmodule

// *** rtl/crxoh_fifo.sv ***
module crxoh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } crxoh_fifo_state_type;

  crxoh_fifo_state_type state_q;
  crxoh_fifo_state_type state_d;
  logic push;
  logic pop;

  assign inReady = state_q.count != (PW+1)'(DEPTH);
  assign outValid = state_q.count != '0;
  assign outData = state_q.mem[state_q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    state_d = state_q;
    if (push)
    begin
      state_d.mem[state_q.wrPtr] = inData;
      state_d.wrPtr = state_q.wrPtr + 1'b1;
    end
    if (pop)
    begin
      state_d.rdPtr = state_q.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      state_d.count = state_q.count + 1'b1;
    end
    else if (pop && !push)
    begin
      state_d.count = state_q.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

endmodule

// *** rtl/crxoh_host.sv ***
module crxoh_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  crxoh_link_if.host link,
  input wire logic setupValid,
  output logic setupReady,
  input wire logic [crxoh_pkg::OBJ_NUM_W-1:0] setupObjectNumber,
  input wire crxoh_pkg::crxoh_obj_type setupObject,
  input wire logic answerValid,
  output logic answerReady,
  input wire logic [crxoh_pkg::OBJ_NUM_W-1:0] answerObjectNumber,
  input wire logic [crxoh_pkg::DLC_W-1:0] answerDlc,
  input wire logic [crxoh_pkg::DATA_W-1:0] answerData,
  input wire logic readValid,
  output logic readReady,
  input wire logic [crxoh_pkg::OBJ_NUM_W-1:0] readObjectNumber,
  output logic readDoneValid,
  output crxoh_pkg::crxoh_obj_type readObject,
  input wire logic busFrameValid,
  output logic busFrameReady,
  input wire crxoh_pkg::crxoh_frame_type busFrame,
  output logic busTxValid,
  input wire logic busTxReady,
  output logic [crxoh_pkg::OBJ_NUM_W-1:0] busTxObjectNumber,
  output crxoh_pkg::crxoh_frame_type busTxFrame
);
  import crxoh_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_CMD, H_WAIT} crxoh_host_fsm_type;

  typedef struct packed {
    crxoh_host_fsm_type fsm;
    crxoh_cmd_type cmd;
    logic readDone;
    crxoh_obj_type readObj;
  } crxoh_host_state_type;

  crxoh_host_state_type state_q;
  crxoh_host_state_type state_d;

  assign setupReady = state_q.fsm == H_IDLE;
  assign answerReady = (state_q.fsm == H_IDLE) && !setupValid;
  assign readReady = (state_q.fsm == H_IDLE) && !setupValid && !answerValid;

  always_comb
  begin
    state_d = state_q;
    state_d.readDone = 1'b0;
    case (state_q.fsm)
      H_IDLE:
      begin
        if (setupValid)
        begin
          state_d.fsm = H_CMD;
          state_d.cmd = '0;
          state_d.cmd.objectNumber = setupObjectNumber;
          state_d.cmd.writeNotRead = 1'b1;
          state_d.cmd.selMask = 1'b1;
          state_d.cmd.selArb = 1'b1;
          state_d.cmd.selCtrl = 1'b1;
          state_d.cmd.selData = 1'b1;
          state_d.cmd.obj = setupObject;
          state_d.cmd.obj.directionTx = 1'b0;
          state_d.cmd.obj.objectValid = 1'b1;
          state_d.cmd.obj.remoteEnable = 1'b0;
          state_d.cmd.obj.endOfBuffer = 1'b1;
          state_d.cmd.obj.transmitRequest = 1'b0;
          state_d.cmd.obj.newDataFlag = 1'b0;
          state_d.cmd.obj.messageLostFlag = 1'b0;
          state_d.cmd.obj.interruptPending = 1'b0;
          if (setupObject.extendedIdFlag && setupObject.useAcceptanceMask)
          begin
            state_d.cmd.obj.maskExtendedFlag = 1'b1;
          end
        end
        else if (answerValid)
        begin
          state_d.fsm = H_CMD;
          state_d.cmd = '0;
          state_d.cmd.objectNumber = answerObjectNumber;
          state_d.cmd.writeNotRead = 1'b1;
          state_d.cmd.selCtrl = 1'b1;
          state_d.cmd.selData = 1'b1;
          state_d.cmd.obj.data = answerData;
          state_d.cmd.obj.dlc = answerDlc;
          state_d.cmd.obj.useAcceptanceMask = 1'b1;
          state_d.cmd.obj.endOfBuffer = 1'b1;
          state_d.cmd.obj.transmitRequest = 1'b1;
        end
        else if (readValid)
        begin
          state_d.fsm = H_CMD;
          state_d.cmd = '0;
          state_d.cmd.objectNumber = readObjectNumber;
          state_d.cmd.clrIntPending = 1'b1;
          state_d.cmd.clrNewData = 1'b1;
        end
      end
      H_CMD:
      begin
        if (link.cmdReady)
        begin
          state_d.fsm = state_q.cmd.writeNotRead ? H_IDLE : H_WAIT;
        end
      end
      H_WAIT:
      begin
        if (link.rspValid)
        begin
          state_d.fsm = H_IDLE;
          state_d.readDone = 1'b1;
          state_d.readObj = link.rsp;
        end
      end
      default:
      begin
        state_d.fsm = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.cmdValid = state_q.fsm == H_CMD;
  assign link.cmd = state_q.cmd;
  assign readDoneValid = state_q.readDone;
  assign readObject = state_q.readObj;
  assign link.frameValid = busFrameValid;
  assign link.frame = busFrame;
  assign busFrameReady = link.frameReady;
  assign busTxValid = link.txValid;
  assign busTxObjectNumber = link.txObjectNumber;
  assign busTxFrame = link.txFrame;
  assign link.txReady = busTxReady;

endmodule

// *** rtl/crxoh_link_if.sv ***
interface crxoh_link_if;
  import crxoh_pkg::*;

  // ----------------------------------------------------------------
  // Interface register set: command and read answer
  // ----------------------------------------------------------------
  logic cmdValid;
  logic cmdReady;
  crxoh_cmd_type cmd;
  logic rspValid;
  crxoh_obj_type rsp;

  // ----------------------------------------------------------------
  // Bus side: received frames in, transmit frames out
  // ----------------------------------------------------------------
  logic frameValid;
  logic frameReady;
  crxoh_frame_type frame;
  logic txValid;
  logic txReady;
  logic [OBJ_NUM_W-1:0] txObjectNumber;
  crxoh_frame_type txFrame;

  modport device (
    input cmdValid,
    input cmd,
    output cmdReady,
    output rspValid,
    output rsp,
    input frameValid,
    input frame,
    output frameReady,
    output txValid,
    output txObjectNumber,
    output txFrame,
    input txReady
  );

  modport host (
    output cmdValid,
    output cmd,
    input cmdReady,
    input rspValid,
    input rsp,
    output frameValid,
    output frame,
    input frameReady,
    input txValid,
    input txObjectNumber,
    input txFrame,
    output txReady
  );

endinterface

// *** rtl/crxoh_pkg.sv ***
package crxoh_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OBJ = 32;
  localparam int OBJ_NUM_W = 6;
  localparam int ID_W = 29;
  localparam int STD_ID_LSB = 18;
  localparam int DLC_W = 4;
  localparam int DATA_W = 64;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Message object, as held in message RAM and in the interface set
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ID_W-1:0] idMaskBits;
    logic maskExtendedFlag;
    logic maskDirection;
    logic [ID_W-1:0] id;
    logic extendedIdFlag;
    logic directionTx;
    logic objectValid;
    logic useAcceptanceMask;
    logic remoteEnable;
    logic receiveInterruptEnable;
    logic endOfBuffer;
    logic transmitRequest;
    logic newDataFlag;
    logic messageLostFlag;
    logic interruptPending;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] data;
  } crxoh_obj_type;

  // ----------------------------------------------------------------
  // Frame on the bus side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ID_W-1:0] id;
    logic extendedIdFlag;
    logic remote;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] data;
  } crxoh_frame_type;

  // ----------------------------------------------------------------
  // Command request with its command mask
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [OBJ_NUM_W-1:0] objectNumber;
    logic writeNotRead;
    logic selMask;
    logic selArb;
    logic selCtrl;
    logic selData;
    logic clrIntPending;
    logic clrNewData;
    crxoh_obj_type obj;
  } crxoh_cmd_type;

  localparam int FRAME_W = $bits(crxoh_frame_type);

endpackage
